// >>> tpw_pkg.sv
// Shared constants and types for the timer function and output enable block
package tpw_pkg;

  // Register byte offsets
  localparam logic [7:0] TPW_OFS_FCTL = 8'h00;
  localparam logic [7:0] TPW_OFS_OE   = 8'h04;
  localparam logic [7:0] TPW_OFS_PWM  = 8'h08;
  localparam logic [7:0] TPW_OFS_IOC  = 8'h0C;
  localparam logic [7:0] TPW_OFS_STAT = 8'h10;

  // Reset values
  localparam logic [7:0]  TPW_RST_FCTL = 8'h80;
  localparam logic [7:0]  TPW_RST_OE   = 8'hFF;
  localparam logic [7:0]  TPW_RST_PWM  = 8'h88;
  localparam logic [15:0] TPW_RST_IOC  = 16'h0000;

  // Fixed-one bit positions
  localparam int TPW_FCTL_RSV_BIT = 7;
  localparam int TPW_PWM_RSV_HI   = 7;
  localparam int TPW_PWM_RSV_LO   = 3;

  // Pins that carry the normal-phase and counter-phase waves in combined modes
  localparam logic [7:0] TPW_NORMAL_PHASE_MASK  = 8'h32;
  localparam logic [7:0] TPW_COUNTER_PHASE_MASK = 8'hC8;

  // Width of one I/O control field (one per pin pair)
  localparam int TPW_IOC_FIELD_W = 4;

  typedef enum logic [1:0] {
    TPW_INDEP       = 2'b00,
    TPW_RSYNC       = 2'b01,
    TPW_COMP_TROUGH = 2'b10,
    TPW_COMP_CREST  = 2'b11
  } tpw_comb_t;

  typedef struct packed {
    logic      rsv_one;
    logic      ext_clk_sel;
    logic      trig_edge;
    logic      trig_en;
    logic      cp_pol;
    logic      np_pol;
    tpw_comb_t comb_mode;
  } tpw_fctl_t;

endpackage

// >>> tpw_pin_cell.sv
// One timer output pin: master enable, mode override and initial level
module tpw_pin_cell (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic srst,
  // Settings
  input  wire logic master_off,
  input  wire logic combined,
  input  wire logic phase_en,
  input  wire logic pol,
  input  wire logic pwm_sel,
  input  wire logic io_drive,
  // Waveform from counter and compare logic
  input  wire logic wave_active,
  input  wire logic match_seen,
  input  wire logic normal_wave,
  input  wire logic init_level,
  // Pin
  output logic      pin_o,
  output logic      pin_oe_n
);

  logic lvl_nxt;
  logic oe_n_nxt;

  always_comb begin
    lvl_nxt  = 1'b0;
    oe_n_nxt = 1'b1;
    if (master_off) begin
      lvl_nxt  = 1'b0;
      oe_n_nxt = 1'b1;
    end else if (combined) begin
      oe_n_nxt = 1'b0;
      if (phase_en) begin
        // Idle level is the inverse of the active level
        lvl_nxt = (match_seen && wave_active) ? pol : ~pol;
      end else begin
        lvl_nxt = wave_active;
      end
    end else if (pwm_sel) begin
      oe_n_nxt = 1'b0;
      lvl_nxt  = wave_active;
    end else if (io_drive) begin
      oe_n_nxt = 1'b0;
      lvl_nxt  = match_seen ? normal_wave : init_level;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pin_o    <= 1'b0;
      pin_oe_n <= 1'b1;
    end else begin
      pin_o    <= lvl_nxt;
      pin_oe_n <= oe_n_nxt;
    end
  end

endmodule

// >>> tpw_trig_unit.sv
// Converter trigger, buffer transfer strobe and external clock gate
module tpw_trig_unit (
  // Clock and reset
  input  wire logic           clk_sys,
  input  wire logic           srst,
  // Settings
  input  wire tpw_pkg::tpw_fctl_t fctl,
  // Counter events and external clock
  input  wire logic           crest_evt,
  input  wire logic           trough_evt,
  input  wire logic           ext_clk_in,
  // Results
  output logic                conv_trig,
  output logic                xfer_strobe,
  output logic                ext_clk_en
);

  logic comp_mode;
  logic edge_hit;
  logic xfer_hit;

  assign comp_mode = fctl.comb_mode[1];
  assign edge_hit  = fctl.trig_edge ? trough_evt : crest_evt;
  assign xfer_hit  = (fctl.comb_mode == tpw_pkg::TPW_COMP_TROUGH) ? trough_evt : crest_evt;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      conv_trig <= 1'b0;
    end else begin
      conv_trig <= comp_mode && fctl.trig_en && edge_hit;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      xfer_strobe <= 1'b0;
    end else begin
      xfer_strobe <= comp_mode && xfer_hit;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ext_clk_en <= 1'b0;
    end else begin
      ext_clk_en <= fctl.ext_clk_sel && ext_clk_in;
    end
  end

endmodule

// >>> tpw_top.sv
// Timer function control and output master enable with APB register access
// Notes on behaviour
// - Function control top bit reads as one
// - Clock-select bit gates the external timer clock
// - Edge bit: zero crest, one trough
// - Enable bit allows one trigger per cycle, in modes 10/11 only
// - Counter-phase polarity sets idle and active levels
// - Normal-phase polarity sets idle and active levels
// - Mode 00: channels run independently
// - Mode 01: joint reset-synchronous PWM
// - Modes 10/11: complementary, trough or crest transfer
// - Combined modes override per-pin PWM bits
// - Enable bit one releases pin to port
// - Bits 7-4 channel 1, 3-0 channel 0
// - Low wake-up input forces all enables to one while wakeup_in_sel is set
// - Pins C/D and A/B follow their I/O fields
// - Combined-mode initial levels come from polarity bits, except pins 0 and 2, which follow wave_active
module tpw_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              srst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // Counter and compare logic
  input  wire logic              crest_evt,
  input  wire logic              trough_evt,
  input  wire logic [7:0]        wave_active,
  input  wire logic [7:0]        match_seen,
  input  wire logic [7:0]        normal_wave,
  input  wire logic [7:0]        init_level,
  input  wire logic              ext_clk_in,
  // Wake-up shutdown
  input  wire logic              wakeup_in_sel,
  input  wire logic              wakeup_shutdown_pin_n,
  // Mode and event outputs
  output tpw_pkg::tpw_comb_t     comb_mode_o,
  output logic [7:0]             pwm_mode_eff,
  output logic                   conv_trig,
  output logic                   xfer_strobe,
  output logic                   ext_clk_en,
  // Timer pins
  output logic [7:0]             pin_o,
  output logic [7:0]             pin_oe_n
);

  tpw_pkg::tpw_fctl_t function_control_reg_r;
  logic [7:0]         output_master_enable_reg_r;
  logic [7:0]         per_pin_pwm_mode_reg_r;
  logic [15:0]        io_control_r;
  logic [31:0]        prdata_nxt;
  logic               addr_hit;
  logic               acc_start;
  logic               wr_en;
  logic               shutdown_req;
  logic               combined;
  logic [7:0]         pwm_sel;
  logic [7:0]         io_drive;

  // I/O field codes with top bit clear and nonzero drive the pin
  function automatic logic io_is_out(input logic [3:0] fld);
    io_is_out = (fld != 4'h0) && !fld[3];
  endfunction

  // Per-pin PWM bit; pin A of each channel has none
  function automatic logic pwm_bit(input logic [7:0] reg_v, input int idx);
    int p;
    int c;
    p = idx % 4;
    c = idx / 4;
    if (p == 0) begin
      pwm_bit = 1'b0;
    end else begin
      pwm_bit = reg_v[c * 4 + p - 1];
    end
  endfunction

  // APB access: one wait state, answer registered
  assign acc_start = psel && penable && !pready;
  assign wr_en     = psel && penable && pready && pwrite;

  always_comb begin
    addr_hit   = 1'b1;
    prdata_nxt = 32'h0000_0000;
    case (paddr[7:0])
      tpw_pkg::TPW_OFS_FCTL: prdata_nxt = {24'h000000, function_control_reg_r};
      tpw_pkg::TPW_OFS_OE:   prdata_nxt = {24'h000000, output_master_enable_reg_r};
      tpw_pkg::TPW_OFS_PWM:  prdata_nxt = {24'h000000, per_pin_pwm_mode_reg_r};
      tpw_pkg::TPW_OFS_IOC:  prdata_nxt = {16'h0000, io_control_r};
      tpw_pkg::TPW_OFS_STAT: prdata_nxt = {16'h0000, pin_oe_n, 5'h00, comb_mode_o[1],
                                           combined, shutdown_req};
      default: begin
        addr_hit   = 1'b0;
        prdata_nxt = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc_start;
      prdata  <= (acc_start && !pwrite) ? prdata_nxt : 32'h0000_0000;
      pslverr <= acc_start && !addr_hit;
    end
  end

  // Function control: top bit is held at one
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      function_control_reg_r <= tpw_pkg::tpw_fctl_t'(tpw_pkg::TPW_RST_FCTL);
    end else if (wr_en && paddr[7:0] == tpw_pkg::TPW_OFS_FCTL) begin
      function_control_reg_r <= tpw_pkg::tpw_fctl_t'({1'b1, pwdata[6:0]});
    end
  end

  // Output master enable: shutdown wins over a write in the same cycle
  assign shutdown_req = wakeup_in_sel && !wakeup_shutdown_pin_n;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      output_master_enable_reg_r <= tpw_pkg::TPW_RST_OE;
    end else if (shutdown_req) begin
      output_master_enable_reg_r <= 8'hFF;
    end else if (wr_en && paddr[7:0] == tpw_pkg::TPW_OFS_OE) begin
      output_master_enable_reg_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      per_pin_pwm_mode_reg_r <= tpw_pkg::TPW_RST_PWM;
    end else if (wr_en && paddr[7:0] == tpw_pkg::TPW_OFS_PWM) begin
      per_pin_pwm_mode_reg_r <= {1'b1, pwdata[6:4], 1'b1, pwdata[2:0]};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      io_control_r <= tpw_pkg::TPW_RST_IOC;
    end else if (wr_en && paddr[7:0] == tpw_pkg::TPW_OFS_IOC) begin
      io_control_r <= pwdata[15:0];
    end
  end

  // Combined modes: 01 reset-synchronous, 1x complementary
  assign combined = function_control_reg_r.comb_mode != tpw_pkg::TPW_INDEP;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      comb_mode_o <= tpw_pkg::TPW_INDEP;
    end else begin
      comb_mode_o <= function_control_reg_r.comb_mode;
    end
  end

  // Effective per-pin PWM selection seen by the channels
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pwm_mode_eff <= 8'h00;
    end else begin
      pwm_mode_eff <= combined ? 8'h00 : pwm_sel;
    end
  end

  tpw_trig_unit u_trig (
    .clk_sys     (clk_sys),
    .srst        (srst),
    .fctl        (function_control_reg_r),
    .crest_evt   (crest_evt),
    .trough_evt  (trough_evt),
    .ext_clk_in  (ext_clk_in),
    .conv_trig   (conv_trig),
    .xfer_strobe (xfer_strobe),
    .ext_clk_en  (ext_clk_en)
  );

  // Bit i: channel i/4, pin A..D for i%4
  for (genvar i = 0; i < 8; i++) begin : g_pin
    logic pol_i;
    assign pwm_sel[i]  = pwm_bit(per_pin_pwm_mode_reg_r, i);
    // Pins C/D use the CD field, A/B the AB field
    assign io_drive[i] = io_is_out(io_control_r[((i / 4) * 2 + (i % 4) / 2) * 4 +: 4]);
    assign pol_i       = tpw_pkg::TPW_COUNTER_PHASE_MASK[i] ? function_control_reg_r.cp_pol
                                                            : function_control_reg_r.np_pol;
    tpw_pin_cell u_cell (
      .clk_sys     (clk_sys),
      .srst        (srst),
      .master_off  (output_master_enable_reg_r[i]),
      .combined    (combined),
      .phase_en    (tpw_pkg::TPW_NORMAL_PHASE_MASK[i] | tpw_pkg::TPW_COUNTER_PHASE_MASK[i]),
      .pol         (pol_i),
      .pwm_sel     (pwm_sel[i]),
      .io_drive    (io_drive[i]),
      .wave_active (wave_active[i]),
      .match_seen  (match_seen[i]),
      .normal_wave (normal_wave[i]),
      .init_level  (init_level[i]),
      .pin_o       (pin_o[i]),
      .pin_oe_n    (pin_oe_n[i])
    );
  end

  // Checks
  rsv_bit_read_a: assert property (@(posedge clk_sys) disable iff (srst)
    (acc_start && !pwrite && paddr[7:0] == tpw_pkg::TPW_OFS_FCTL) |=> (pready && prdata[7]))
    else $error("reserved function bit did not read as one");

  ext_clk_gate_a: assert property (@(posedge clk_sys) disable iff (srst)
    ext_clk_en |-> $past(function_control_reg_r.ext_clk_sel) && $past(ext_clk_in))
    else $error("external clock passed while disabled");

  trig_crest_a: assert property (@(posedge clk_sys) disable iff (srst)
    (function_control_reg_r.comb_mode[1] && function_control_reg_r.trig_en
     && !function_control_reg_r.trig_edge && crest_evt) |=> conv_trig)
    else $error("crest trigger missing");

  trig_gate_a: assert property (@(posedge clk_sys) disable iff (srst)
    conv_trig |-> ($past(function_control_reg_r.trig_en)
                   && $past(function_control_reg_r.comb_mode[1])))
    else $error("trigger outside enabled complementary mode");

  xfer_trough_a: assert property (@(posedge clk_sys) disable iff (srst)
    (function_control_reg_r.comb_mode == tpw_pkg::TPW_COMP_TROUGH && trough_evt)
    |=> xfer_strobe)
    else $error("trough transfer missing");

  normal_init_a: assert property (@(posedge clk_sys) disable iff (srst)
    (combined && !match_seen[1] && !output_master_enable_reg_r[1])
    |=> (pin_o[1] == !$past(function_control_reg_r.np_pol) && !pin_oe_n[1]))
    else $error("normal-phase initial level wrong");

  counter_init_a: assert property (@(posedge clk_sys) disable iff (srst)
    (combined && !match_seen[3] && !output_master_enable_reg_r[3])
    |=> (pin_o[3] == !$past(function_control_reg_r.cp_pol)))
    else $error("counter-phase initial level wrong");

  shutdown_all_a: assert property (@(posedge clk_sys) disable iff (srst)
    shutdown_req |=> (output_master_enable_reg_r == 8'hFF) ##1 (pin_oe_n == 8'hFF))
    else $error("shutdown did not release all pins");

  pin_release_a: assert property (@(posedge clk_sys) disable iff (srst)
    output_master_enable_reg_r[5] |=> (pin_oe_n[5] && !pin_o[5]))
    else $error("disabled pin still driven");

  override_a: assert property (@(posedge clk_sys) disable iff (srst)
    (combined && !output_master_enable_reg_r[2]) |=> (!pin_oe_n[2] && pwm_mode_eff == 8'h00))
    else $error("combined mode did not override pin settings");

  // Register bus checks
  err_resp_a: assert property (@(posedge clk_sys) disable iff (srst)
    (acc_start && !addr_hit) |=> (pready && pslverr && prdata == 32'h0000_0000))
    else $error("unmapped access was not refused");

  fctl_write_a: assert property (@(posedge clk_sys) disable iff (srst)
    (wr_en && paddr[7:0] == tpw_pkg::TPW_OFS_FCTL)
    |=> (function_control_reg_r.rsv_one && function_control_reg_r[6:0] == $past(pwdata[6:0])))
    else $error("function control write did not land");

  oe_write_a: assert property (@(posedge clk_sys) disable iff (srst)
    (wr_en && paddr[7:0] == tpw_pkg::TPW_OFS_OE && !shutdown_req)
    |=> (output_master_enable_reg_r == $past(pwdata[7:0])))
    else $error("output enable write did not land");

  shutdown_wins_a: assert property (@(posedge clk_sys) disable iff (srst)
    (shutdown_req && wr_en && paddr[7:0] == tpw_pkg::TPW_OFS_OE)
    |=> (output_master_enable_reg_r == 8'hFF))
    else $error("enable write beat a shutdown request");

  // Trigger, transfer and clock gate checks
  ext_clk_pass_a: assert property (@(posedge clk_sys) disable iff (srst)
    (function_control_reg_r.ext_clk_sel && ext_clk_in) |=> ext_clk_en)
    else $error("enabled external clock was blocked");

  trig_trough_a: assert property (@(posedge clk_sys) disable iff (srst)
    (function_control_reg_r.comb_mode[1] && function_control_reg_r.trig_en
     && function_control_reg_r.trig_edge && trough_evt) |=> conv_trig)
    else $error("trough trigger missing");

  trig_idle_a: assert property (@(posedge clk_sys) disable iff (srst)
    !function_control_reg_r.comb_mode[1] |=> (!conv_trig && !xfer_strobe))
    else $error("trigger or transfer outside complementary mode");

  xfer_crest_a: assert property (@(posedge clk_sys) disable iff (srst)
    (function_control_reg_r.comb_mode == tpw_pkg::TPW_COMP_CREST && crest_evt)
    |=> xfer_strobe)
    else $error("crest transfer missing");

  // Mode and pin checks
  mode_copy_a: assert property (@(posedge clk_sys) disable iff (srst)
    (function_control_reg_r.comb_mode == tpw_pkg::TPW_RSYNC)
    |=> (comb_mode_o == tpw_pkg::TPW_RSYNC && pwm_mode_eff == 8'h00))
    else $error("reset-synchronous mode not applied");

  indep_pwm_a: assert property (@(posedge clk_sys) disable iff (srst)
    (!combined && per_pin_pwm_mode_reg_r[4]) |=> pwm_mode_eff[5])
    else $error("per-pin PWM bit ignored in independent mode");

  normal_active_a: assert property (@(posedge clk_sys) disable iff (srst)
    (combined && match_seen[1] && wave_active[1] && !output_master_enable_reg_r[1])
    |=> (pin_o[1] == $past(function_control_reg_r.np_pol)))
    else $error("normal-phase active level wrong");

  counter_active_a: assert property (@(posedge clk_sys) disable iff (srst)
    (combined && match_seen[3] && wave_active[3] && !output_master_enable_reg_r[3])
    |=> (pin_o[3] == $past(function_control_reg_r.cp_pol)))
    else $error("counter-phase active level wrong");

  init_phase_a: assert property (@(posedge clk_sys) disable iff (srst)
    (combined && !match_seen[4] && init_level[4] && !output_master_enable_reg_r[4])
    |=> (pin_o[4] == !$past(function_control_reg_r.np_pol)))
    else $error("initial-output level used in a combined mode");

  io_follow_a: assert property (@(posedge clk_sys) disable iff (srst)
    (!combined && !output_master_enable_reg_r[0] && io_is_out(io_control_r[3:0]))
    |=> (!pin_oe_n[0] && pin_o[0] == $past(match_seen[0] ? normal_wave[0] : init_level[0])))
    else $error("pin A of channel 0 ignored its I/O field");

  pwm_pin_a: assert property (@(posedge clk_sys) disable iff (srst)
    (!combined && !output_master_enable_reg_r[2] && per_pin_pwm_mode_reg_r[1])
    |=> (!pin_oe_n[2] && pin_o[2] == $past(wave_active[2])))
    else $error("PWM-selected pin not driven");

  pin_d_off_a: assert property (@(posedge clk_sys) disable iff (srst)
    output_master_enable_reg_r[7] |=> (pin_oe_n[7] && !pin_o[7]))
    else $error("channel 1 pin D enable bit misplaced");

  comp_trig_c: cover property (@(posedge clk_sys) disable iff (srst) conv_trig);
  xfer_c:      cover property (@(posedge clk_sys) disable iff (srst) xfer_strobe);
  shutdown_c:  cover property (@(posedge clk_sys) disable iff (srst)
    shutdown_req && wr_en && paddr[7:0] == tpw_pkg::TPW_OFS_OE);
  rsync_c:     cover property (@(posedge clk_sys) disable iff (srst)
    comb_mode_o == tpw_pkg::TPW_RSYNC && !pin_oe_n[1]);
  bad_addr_c:  cover property (@(posedge clk_sys) disable iff (srst) pslverr);

endmodule

// >>> tpw_load_model.sv
// External loads on the eight timer pins, each pad with a pull-down resistor
module tpw_load_model (
  // Pin drive from the timer
  input  wire logic [7:0] pin_o,
  input  wire logic [7:0] pin_oe_n,
  // Pad levels seen by the loads
  output logic      [7:0] pad
);
  timeunit 1ns;
  timeprecision 100ps;
  // A released pad falls to the pull-down level, never keeps the last value
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pad[i] = pin_oe_n[i] ? 1'b0 : pin_o[i];
    end
  end
endmodule

// >>> tpw_top_tb.sv
// Self-checking bench for the timer function control and output enable block
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tpw_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [7:0]  fc, oe, pw;
    logic [15:0] io;
    logic [7:0]  wa, ms, nw, il, pad, oen, eff;
  } tpw_row_t;
  logic               clk_sys, srst, psel, penable, pwrite, pready, pslverr, err, xs;
  logic               crest_evt, trough_evt, ext_clk_in, wakeup_in_sel, wakeup_shutdown_pin_n;
  logic               conv_trig, xfer_strobe, ext_clk_en;
  logic [7:0]         paddr, wave_active, match_seen, normal_wave, init_level;
  logic [7:0]         pwm_mode_eff, pin_o, pin_oe_n, pad;
  logic [31:0]        pwdata, prdata, rd, st;
  tpw_pkg::tpw_comb_t comb_mode_o;
  int                 n_errors, n_compared;
  tpw_row_t           rows [10] = '{
    '{8'h80, 8'h00, 8'h88, 16'h0000, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00},
    '{8'h81, 8'h00, 8'h88, 16'h0000, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFA, 8'h00, 8'h00},
    '{8'h8D, 8'h00, 8'hFF, 16'h0000, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'h05, 8'h00, 8'h00},
    '{8'h86, 8'h00, 8'h88, 16'h0000, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h37, 8'h00, 8'h00},
    '{8'h8B, 8'h00, 8'h88, 16'h0000, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h32, 8'h00, 8'h00},
    '{8'h81, 8'h0F, 8'h88, 16'h0000, 8'h00, 8'h00, 8'h00, 8'h00, 8'hF0, 8'h0F, 8'h00},
    '{8'h80, 8'h00, 8'h81, 16'h0000, 8'h02, 8'h00, 8'h00, 8'h00, 8'h02, 8'hFD, 8'h02},
    '{8'h80, 8'h00, 8'h88, 16'h8001, 8'h00, 8'h01, 8'h01, 8'h02, 8'h03, 8'hFC, 8'h00},
    '{8'h80, 8'h00, 8'h88, 16'h0110, 8'h00, 8'h00, 8'h00, 8'h28, 8'h28, 8'hC3, 8'h00},
    '{8'h80, 8'h00, 8'h81, 16'h0001, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h01, 8'hFC, 8'h02}};

  tpw_top dut_u (.clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .crest_evt(crest_evt), .trough_evt(trough_evt),
    .wave_active(wave_active), .match_seen(match_seen), .normal_wave(normal_wave),
    .init_level(init_level), .ext_clk_in(ext_clk_in), .wakeup_in_sel(wakeup_in_sel),
    .wakeup_shutdown_pin_n(wakeup_shutdown_pin_n), .comb_mode_o(comb_mode_o),
    .pwm_mode_eff(pwm_mode_eff), .conv_trig(conv_trig), .xfer_strobe(xfer_strobe),
    .ext_clk_en(ext_clk_en), .pin_o(pin_o), .pin_oe_n(pin_oe_n));
  tpw_load_model load_u (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .pad(pad));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // One APB transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (k >= 16) begin
      n_errors++;
      close_out();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, x)
    `CHK(err, 1'b0)
  endtask

  initial begin
    repeat (100000) @(posedge clk_sys);
    n_errors++;
    close_out();
  end

  initial begin
    {srst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    {crest_evt, trough_evt, ext_clk_in, wakeup_in_sel} = 4'h0;
    wakeup_shutdown_pin_n = 1'b1;
    {wave_active, match_seen, normal_wave, init_level} = 32'h0;
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    #1;
    `CHK({pready, conv_trig, pin_oe_n}, 10'h0FF)
    rdc(tpw_pkg::TPW_OFS_FCTL, 32'h0000_0080);
    rdc(tpw_pkg::TPW_OFS_OE, 32'h0000_00FF);
    rdc(tpw_pkg::TPW_OFS_PWM, 32'h0000_0088);
    rdc(tpw_pkg::TPW_OFS_IOC, 32'h0000_0000);
    rdc(tpw_pkg::TPW_OFS_STAT, 32'h0000_FF00);
    wr(tpw_pkg::TPW_OFS_FCTL, 32'h0000_0000);
    rdc(tpw_pkg::TPW_OFS_FCTL, 32'h0000_0080);
    // Unmapped place: refused, write dropped
    apb(1'b1, 8'h14, 32'h0000_00FF);
    `CHK(err, 1'b1)
    apb(1'b0, 8'h14, 32'h0000_0000);
    `CHK({err, rd}, {1'b1, 32'h0}) 
    rdc(tpw_pkg::TPW_OFS_FCTL, 32'h0000_0080);
    // Counter inputs still hold the previous row's values whenever the mode field changes here
    foreach (rows[i]) begin
      wr(tpw_pkg::TPW_OFS_FCTL, {24'h0, rows[i].fc});
      wr(tpw_pkg::TPW_OFS_OE, {24'h0, rows[i].oe});
      wr(tpw_pkg::TPW_OFS_PWM, {24'h0, rows[i].pw});
      wr(tpw_pkg::TPW_OFS_IOC, {16'h0, rows[i].io});
      @(posedge clk_sys);
      wave_active <= rows[i].wa;
      match_seen <= rows[i].ms;
      normal_wave <= rows[i].nw;
      init_level <= rows[i].il;
      repeat (3) @(posedge clk_sys);
      #1;
      `CHK(pad, rows[i].pad)
      `CHK(pin_oe_n, rows[i].oen)
      `CHK(pwm_mode_eff, rows[i].eff)
      `CHK(comb_mode_o, rows[i].fc[1:0])
      rdc(tpw_pkg::TPW_OFS_PWM, {24'h0, rows[i].pw | 8'h88});
      st = {16'h0, rows[i].oen, 5'h00, rows[i].fc[1], |rows[i].fc[1:0], 1'b0};
      rdc(tpw_pkg::TPW_OFS_STAT, st);
    end
    // Converter trigger: every mode, edge and enable, crest then trough
    for (int m = 0; m < 4; m++) begin
      for (int f = 0; f < 4; f++) begin
        wr(tpw_pkg::TPW_OFS_FCTL, 32'h80 | (f << 4) | m);
        for (int t = 0; t < 2; t++) begin
          @(posedge clk_sys);
          crest_evt <= (t == 0);
          trough_evt <= (t == 1);
          @(posedge clk_sys);
          crest_evt <= 1'b0;
          trough_evt <= 1'b0;
          #1;
          `CHK(conv_trig, m[1] & f[0] & (f[1] == t))
          xs = xfer_strobe;
          @(posedge clk_sys);
          #1;
          `CHK(conv_trig, 1'b0)
          xs = xs | xfer_strobe;
          `CHK(xs, (m == 2 && t == 1) || (m == 3 && t == 0))
        end
      end
    end
    // External clock gate, closed then open
    for (int s = 0; s < 2; s++) begin
      wr(tpw_pkg::TPW_OFS_FCTL, 32'h80 | (s << 6));
      @(posedge clk_sys);
      ext_clk_in <= 1'b1;
      repeat (3) @(posedge clk_sys);
      #1;
      `CHK(ext_clk_en, s[0])
      ext_clk_in <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
      `CHK(ext_clk_en, 1'b0)
    end
    // Wake-up shutdown: ignored unless the pin is an input, then latched
    wr(tpw_pkg::TPW_OFS_FCTL, 32'h0000_0081);
    wr(tpw_pkg::TPW_OFS_OE, 32'h0000_0000);
    @(posedge clk_sys);
    wakeup_shutdown_pin_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK(pin_oe_n, 8'h00)
    wakeup_in_sel <= 1'b1;
    @(posedge clk_sys);
    wakeup_in_sel <= 1'b0;
    wakeup_shutdown_pin_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK({pin_oe_n, pad}, 16'hFF00)
    rdc(tpw_pkg::TPW_OFS_OE, 32'h0000_00FF);
    // Shutdown held while software clears the enables: shutdown wins
    wakeup_in_sel <= 1'b1;
    wakeup_shutdown_pin_n <= 1'b0;
    wr(tpw_pkg::TPW_OFS_OE, 32'h0000_0000);
    rdc(tpw_pkg::TPW_OFS_STAT, 32'h0000_FF03);
    wakeup_in_sel <= 1'b0;
    wakeup_shutdown_pin_n <= 1'b1;
    rdc(tpw_pkg::TPW_OFS_OE, 32'h0000_00FF);
    // Second reset in mid-run restores registers and releases the pins
    wr(tpw_pkg::TPW_OFS_FCTL, 32'h0000_009F);
    wr(tpw_pkg::TPW_OFS_OE, 32'h0000_0000);
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    #1;
    `CHK({pready, conv_trig, comb_mode_o, pwm_mode_eff, pin_oe_n}, 20'h000FF)
    rdc(tpw_pkg::TPW_OFS_FCTL, 32'h0000_0080);
    rdc(tpw_pkg::TPW_OFS_OE, 32'h0000_00FF);
    close_out();
  end
endmodule
